// ===== verilog/dtcru_pkg.sv
// dtcru_pkg: register map, field layout and reset values for the dual timer unit
// assumes a 16-bit plain register port and a single 125 MHz clock
package dtcru_pkg;
	localparam int unsigned DTCRU_AW             = 4;
	localparam int unsigned DTCRU_DW             = 16;
	// register offsets
	localparam logic [3:0]  DTCRU_OFS_AUX_CFG    = 4'h0;
	localparam logic [3:0]  DTCRU_OFS_CORE_CFG   = 4'h1;
	localparam logic [3:0]  DTCRU_OFS_AUX_CNT    = 4'h2;
	localparam logic [3:0]  DTCRU_OFS_CORE_CNT   = 4'h3;
	localparam logic [3:0]  DTCRU_OFS_CAPTURE_RELOAD_REGISTER_VAL = 4'h4;
	localparam logic [3:0]  DTCRU_OFS_CAP_CFG    = 4'h5;
	localparam logic [3:0]  DTCRU_OFS_IRQ_STAT   = 4'h6;
	localparam logic [3:0]  DTCRU_OFS_IRQ_MASK   = 4'h7;
	// timer config fields
	localparam int unsigned DTCRU_TC_RUN         = 0;
	localparam int unsigned DTCRU_TC_DOWN        = 1;
	localparam int unsigned DTCRU_TC_PINDIR      = 2;
	localparam int unsigned DTCRU_TC_SRC_LO      = 3;   // 2 bits: source select
	localparam int unsigned DTCRU_TC_PRE_LO      = 5;   // 3 bits: prescale exponent
	localparam int unsigned DTCRU_TC_EDGE_LO     = 8;   // 2 bits: external edge select
	localparam int unsigned DTCRU_TC_RELOAD      = 10;  // core only: reload on overflow
	localparam int unsigned DTCRU_TC_OUT_EN      = 11;  // core only: toggle latch to pin
	localparam int unsigned DTCRU_TC_LATCH       = 12;  // core only: latch state (read)
	// capture config fields
	localparam int unsigned DTCRU_CC_EDGE_LO     = 0;   // 2 bits
	localparam int unsigned DTCRU_CC_TRIG_LO     = 2;   // 2 bits: trigger source
	localparam int unsigned DTCRU_CC_CLEAR       = 4;
	// interrupt bits
	localparam int unsigned DTCRU_IRQ_AUX_OVF    = 0;
	localparam int unsigned DTCRU_IRQ_CORE_OVF   = 1;
	localparam int unsigned DTCRU_IRQ_CAPTURE    = 2;
	localparam int unsigned DTCRU_IRQ_W          = 3;
	// source encodings
	localparam logic [1:0]  DTCRU_SRC_PRESCALE   = 2'h0;
	localparam logic [1:0]  DTCRU_SRC_PIN        = 2'h1;
	localparam logic [1:0]  DTCRU_SRC_LATCH      = 2'h2;  // aux only
	// edge encodings
	localparam logic [1:0]  DTCRU_EDGE_NONE      = 2'h0;
	localparam logic [1:0]  DTCRU_EDGE_RISE      = 2'h1;
	localparam logic [1:0]  DTCRU_EDGE_FALL      = 2'h2;
	localparam logic [1:0]  DTCRU_EDGE_BOTH      = 2'h3;
	// capture trigger encodings
	localparam logic [1:0]  DTCRU_TRIG_CAPTURE_INPUT_PIN     = 2'h0;
	localparam logic [1:0]  DTCRU_TRIG_FCOUNT    = 2'h1;
	localparam logic [1:0]  DTCRU_TRIG_FDIR      = 2'h2;
	localparam logic [1:0]  DTCRU_TRIG_FBOTH     = 2'h3;
	// finest prescaler count step in system clocks
	localparam int unsigned DTCRU_MIN_DIV        = 2;
	localparam logic [15:0] DTCRU_CFG_RST        = 16'h0000;
endpackage

// ===== verilog/dtcru_edge.sv
// dtcru_edge: edge detector for one synchronous input
// assumes the input is already synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module dtcru_edge
	import dtcru_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	input  wire logic       sig_in,
	input  wire logic [1:0] edge_sel,
	output logic            edge_hit
);
	logic prev;

	// remember last level
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			prev <= 1'b0;
		end else begin
			prev <= sig_in;
		end
	end

	// select rising, falling or both
	always_comb begin
		edge_hit = 1'b0;
		case (edge_sel)
			DTCRU_EDGE_RISE: edge_hit = sig_in & ~prev;
			DTCRU_EDGE_FALL: edge_hit = ~sig_in & prev;
			DTCRU_EDGE_BOTH: edge_hit = sig_in ^ prev;
			default:         edge_hit = 1'b0;
		endcase
	end
endmodule // dtcru_edge
`default_nettype wire

// ===== verilog/dtcru_top.sv
// dtcru_top: two 16-bit up/down timers with capture/reload register
// assumes synchronous pins, one 125 MHz clock, plain register port
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module dtcru_top
	import dtcru_pkg::*;
#(
	parameter int unsigned TW = 16
)(
	input  wire logic                ref_clk,
	input  wire logic                sys_rst,
	input  wire logic [DTCRU_AW-1:0] reg_addr,
	input  wire logic [DTCRU_DW-1:0] reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic      [DTCRU_DW-1:0] reg_rdata,
	input  wire logic                aux_count_input,
	input  wire logic                core_count_input,
	input  wire logic                aux_direction_input_pin,
	input  wire logic                core_direction_input_pin,
	input  wire logic                capture_input_pin,
	input  wire logic                first_core_count_input,
	input  wire logic                first_core_direction_input,
	output logic                     toggle_output_pin,
	output logic                     compare_unit_clock,
	output logic                     irq
);
	import dtcru_pkg::*;

	// elaboration check: the count and wrap logic is built for 16-bit timers only
	if (TW != 16) begin : g_tw_chk
		$error("dtcru_top: timer width must be 16");
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [15:0]          aux_cfg;
	logic [15:0]          core_cfg;
	logic [4:0]           cap_cfg;
	logic [TW-1:0]        auxiliary_timer;
	logic [TW-1:0]        core_timer;
	logic [TW-1:0]        capture_reload_register;
	logic                 core_toggle_latch;
	logic [DTCRU_IRQ_W-1:0] irq_stat;
	logic [DTCRU_IRQ_W-1:0] irq_mask;
	logic [7:0]           pre_cnt;
	logic                 pre_phase;

	// ------------------------------------------------------------
	// event detection
	// ------------------------------------------------------------
	logic aux_pin_hit;
	logic core_pin_hit;
	logic cap_pin_hit;
	logic fcnt_hit;
	logic fdir_hit;
	logic latch_prev;

	// external count edges for each timer
	dtcru_edge u_aux_edge (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.sig_in   (aux_count_input),
		.edge_sel (aux_cfg[DTCRU_TC_EDGE_LO +: 2]),
		.edge_hit (aux_pin_hit)
	);
	dtcru_edge u_core_edge (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.sig_in   (core_count_input),
		.edge_sel (core_cfg[DTCRU_TC_EDGE_LO +: 2]),
		.edge_hit (core_pin_hit)
	);
	// capture pin with programmable edge
	dtcru_edge u_cap_edge (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.sig_in   (capture_input_pin),
		.edge_sel (cap_cfg[DTCRU_CC_EDGE_LO +: 2]),
		.edge_hit (cap_pin_hit)
	);
	// first module inputs, any transition
	dtcru_edge u_fcnt_edge (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.sig_in   (first_core_count_input),
		.edge_sel (DTCRU_EDGE_BOTH),
		.edge_hit (fcnt_hit)
	);
	dtcru_edge u_fdir_edge (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.sig_in   (first_core_direction_input),
		.edge_sel (DTCRU_EDGE_BOTH),
		.edge_hit (fdir_hit)
	);

	// ------------------------------------------------------------
	// prescaler
	// ------------------------------------------------------------
	// free-running half-rate phase and divider bits
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pre_phase <= 1'b0;
			pre_cnt   <= 8'h00;
		end else begin
			pre_phase <= ~pre_phase;
			if (pre_phase) pre_cnt <= pre_cnt + 8'h01;
		end
	end

	// tick when all low divider bits are ones, so rate is 2*2^n clocks
	function automatic logic pre_tick(input logic [2:0] exp_sel, input logic [7:0] cnt, input logic ph);
		logic [7:0] m;
		m = (8'h01 << exp_sel) - 8'h01;
		pre_tick = ph & ((cnt & m) == m);
	endfunction

	// ------------------------------------------------------------
	// count enables
	// ------------------------------------------------------------
	logic aux_step;
	logic core_step;
	logic aux_down;
	logic core_down;
	logic latch_edge;
	logic core_wrap;
	logic aux_wrap;
	logic capture_go;

	// latch transitions used as aux clock
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			latch_prev <= 1'b0;
		end else begin
			latch_prev <= core_toggle_latch;
		end
	end
	assign latch_edge = latch_prev ^ core_toggle_latch;

	// source selection per timer
	always_comb begin
		aux_step = 1'b0;
		case (aux_cfg[DTCRU_TC_SRC_LO +: 2])
			DTCRU_SRC_PRESCALE: aux_step = pre_tick(aux_cfg[DTCRU_TC_PRE_LO +: 3], pre_cnt, pre_phase);
			DTCRU_SRC_PIN:      aux_step = aux_pin_hit;
			DTCRU_SRC_LATCH:    aux_step = latch_edge;
			default:            aux_step = 1'b0;
		endcase
		aux_step = aux_step & aux_cfg[DTCRU_TC_RUN];
		core_step = 1'b0;
		case (core_cfg[DTCRU_TC_SRC_LO +: 2])
			DTCRU_SRC_PRESCALE: core_step = pre_tick(core_cfg[DTCRU_TC_PRE_LO +: 3], pre_cnt, pre_phase);
			DTCRU_SRC_PIN:      core_step = core_pin_hit;
			default:            core_step = 1'b0;
		endcase
		core_step = core_step & core_cfg[DTCRU_TC_RUN];
	end

	// direction: software bit, or pin level when enabled
	assign aux_down  = aux_cfg[DTCRU_TC_PINDIR]  ? aux_direction_input_pin  : aux_cfg[DTCRU_TC_DOWN];
	assign core_down = core_cfg[DTCRU_TC_PINDIR] ? core_direction_input_pin : core_cfg[DTCRU_TC_DOWN];

	// wrap detection
	assign core_wrap = core_step & (core_down ? (core_timer == '0) : (core_timer == '1));
	assign aux_wrap  = aux_step  & (aux_down  ? (auxiliary_timer == '0) : (auxiliary_timer == '1));

	// capture trigger selection
	always_comb begin
		capture_go = 1'b0;
		case (cap_cfg[DTCRU_CC_TRIG_LO +: 2])
			DTCRU_TRIG_CAPTURE_INPUT_PIN:  capture_go = cap_pin_hit;
			DTCRU_TRIG_FCOUNT: capture_go = fcnt_hit;
			DTCRU_TRIG_FDIR:   capture_go = fdir_hit;
			DTCRU_TRIG_FBOTH:  capture_go = fcnt_hit | fdir_hit;
			default:           capture_go = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	logic wr_aux_cfg;
	logic wr_core_cfg;
	logic wr_aux_cnt;
	logic wr_core_cnt;
	logic wr_capture_reload_register;
	logic wr_cap_cfg;
	logic wr_stat;
	logic wr_mask;

	// address decode
	always_comb begin
		wr_aux_cfg  = 1'b0;
		wr_core_cfg = 1'b0;
		wr_aux_cnt  = 1'b0;
		wr_core_cnt = 1'b0;
		wr_capture_reload_register   = 1'b0;
		wr_cap_cfg  = 1'b0;
		wr_stat     = 1'b0;
		wr_mask     = 1'b0;
		if (reg_wr) begin
			if (reg_addr == DTCRU_OFS_AUX_CFG) wr_aux_cfg = 1'b1;
			else if (reg_addr == DTCRU_OFS_CORE_CFG) wr_core_cfg = 1'b1;
			else if (reg_addr == DTCRU_OFS_AUX_CNT) wr_aux_cnt = 1'b1;
			else if (reg_addr == DTCRU_OFS_CORE_CNT) wr_core_cnt = 1'b1;
			else if (reg_addr == DTCRU_OFS_CAPTURE_RELOAD_REGISTER_VAL) wr_capture_reload_register = 1'b1;
			else if (reg_addr == DTCRU_OFS_CAP_CFG) wr_cap_cfg = 1'b1;
			else if (reg_addr == DTCRU_OFS_IRQ_STAT) wr_stat = 1'b1;
			else if (reg_addr == DTCRU_OFS_IRQ_MASK) wr_mask = 1'b1;
		end
	end

	// configuration registers
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			aux_cfg  <= DTCRU_CFG_RST;
			core_cfg <= DTCRU_CFG_RST;
			cap_cfg  <= 5'h00;
			irq_mask <= 3'h0;
		end else begin
			if (wr_aux_cfg)  aux_cfg  <= reg_wdata;
			if (wr_core_cfg) core_cfg <= reg_wdata;
			if (wr_cap_cfg)  cap_cfg  <= reg_wdata[4:0];
			if (wr_mask)     irq_mask <= reg_wdata[DTCRU_IRQ_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// timers
	// ------------------------------------------------------------
	// auxiliary timer: capture clear beats count, software write beats all
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			auxiliary_timer <= '0;
		end else if (wr_aux_cnt) begin
			auxiliary_timer <= reg_wdata;
		end else if (capture_go && cap_cfg[DTCRU_CC_CLEAR]) begin
			auxiliary_timer <= '0;
		end else if (aux_step) begin
			auxiliary_timer <= aux_down ? auxiliary_timer - 16'h0001 : auxiliary_timer + 16'h0001;
		end
	end

	// core timer with optional reload on wrap
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			core_timer <= '0;
		end else if (wr_core_cnt) begin
			core_timer <= reg_wdata;
		end else if (core_wrap && core_cfg[DTCRU_TC_RELOAD]) begin
			core_timer <= capture_reload_register;
		end else if (core_step) begin
			core_timer <= core_down ? core_timer - 16'h0001 : core_timer + 16'h0001;
		end
	end

	// toggle latch flips on each core wrap
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			core_toggle_latch <= 1'b0;
		end else if (core_wrap) begin
			core_toggle_latch <= ~core_toggle_latch;
		end
	end

	// capture/reload register: hardware capture beats software write
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			capture_reload_register <= '0;
		end else if (capture_go) begin
			capture_reload_register <= auxiliary_timer;
		end else if (wr_capture_reload_register) begin
			capture_reload_register <= reg_wdata;
		end
	end

	// pin and compare unit outputs
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			toggle_output_pin  <= 1'b0;
			compare_unit_clock <= 1'b0;
		end else begin
			toggle_output_pin  <= core_cfg[DTCRU_TC_OUT_EN] & (core_toggle_latch ^ core_wrap);
			compare_unit_clock <= core_wrap;
		end
	end

	// ------------------------------------------------------------
	// interrupts
	// ------------------------------------------------------------
	logic [DTCRU_IRQ_W-1:0] irq_set;
	assign irq_set = {capture_go, core_wrap, aux_wrap};

	// sticky status, set wins over write-one-to-clear
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			irq_stat <= 3'h0;
		end else begin
			irq_stat <= (irq_stat & ~(wr_stat ? reg_wdata[DTCRU_IRQ_W-1:0] : 3'h0)) | irq_set;
		end
	end
	assign irq = |(irq_stat & irq_mask);

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	// one-cycle read latency, unmapped reads zero
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			if (reg_addr == DTCRU_OFS_AUX_CFG) reg_rdata <= aux_cfg;
			else if (reg_addr == DTCRU_OFS_CORE_CFG) reg_rdata <= {core_cfg[15:13], core_toggle_latch, core_cfg[11:0]};
			else if (reg_addr == DTCRU_OFS_AUX_CNT) reg_rdata <= auxiliary_timer;
			else if (reg_addr == DTCRU_OFS_CORE_CNT) reg_rdata <= core_timer;
			else if (reg_addr == DTCRU_OFS_CAPTURE_RELOAD_REGISTER_VAL) reg_rdata <= capture_reload_register;
			else if (reg_addr == DTCRU_OFS_CAP_CFG) reg_rdata <= {11'h000, cap_cfg};
			else if (reg_addr == DTCRU_OFS_IRQ_STAT) reg_rdata <= {13'h0000, irq_stat};
			else if (reg_addr == DTCRU_OFS_IRQ_MASK) reg_rdata <= {13'h0000, irq_mask};
			else reg_rdata <= 16'h0000;
		end else begin
			reg_rdata <= 16'h0000;
		end
	end
endmodule // dtcru_top
`default_nettype wire

// ===== sim/dtcru_chk.sv
// dtcru_chk: port-level assertions for the dual timer unit
// assumes bind onto dtcru_top, one clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module dtcru_chk
	import dtcru_pkg::*;
#(
	parameter int unsigned TW = 16
)(
	input wire logic                          ref_clk,
	input wire logic                          sys_rst,
	input wire logic [dtcru_pkg::DTCRU_AW-1:0] reg_addr,
	input wire logic [dtcru_pkg::DTCRU_DW-1:0] reg_wdata,
	input wire logic                          reg_wr,
	input wire logic                          reg_rd,
	input wire logic [dtcru_pkg::DTCRU_DW-1:0] reg_rdata,
	input wire logic                          toggle_output_pin,
	input wire logic                          compare_unit_clock,
	input wire logic                          irq
);
	logic [2:0] wr_h;
	logic       cmp_q;
	logic [2:0] mask_sh;
	// write history, pulse history and interrupt mask shadow
	always_ff @(posedge ref_clk) begin
		wr_h  <= {wr_h[1:0], reg_wr};
		cmp_q <= compare_unit_clock;
		if (sys_rst) begin
			mask_sh <= 3'h0;
		end else if (reg_wr && reg_addr == DTCRU_OFS_IRQ_MASK) begin
			mask_sh <= reg_wdata[2:0];
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// no register write near the pin change
	sequence quiet_s;
		!reg_wr && wr_h == 3'h0;
	endsequence
	// a compare pulse just before, now or soon after
	sequence cmp_near_s;
		##[0:2] (compare_unit_clock || cmp_q);
	endsequence
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data not zero outside answer cycle");
	unmapped_rd_a: assert property (reg_rd && reg_addr > DTCRU_OFS_IRQ_MASK |=> reg_rdata == 16'h0000)
		else $error("unmapped read returned data");
	rst_quiet_a: assert property (disable iff (1'b0) sys_rst |=> !irq && !toggle_output_pin
		&& !compare_unit_clock && reg_rdata == 16'h0000) else $error("outputs active after reset");
	cmp_single_a: assert property (compare_unit_clock |=> !compare_unit_clock)
		else $error("compare pulse longer than one cycle");
	toggle_cause_a: assert property ($changed(toggle_output_pin) ##0 quiet_s |-> cmp_near_s)
		else $error("toggle pin moved without a core wrap");
	toggle_rate_a: assert property ($changed(toggle_output_pin) ##0 quiet_s |=> $stable(toggle_output_pin))
		else $error("toggle pin moved on adjacent cycles");
	irq_masked_a: assert property (mask_sh == 3'h0 |-> !irq)
		else $error("interrupt high with all sources masked");
	mask_read_a: assert property (reg_rd && reg_addr == DTCRU_OFS_IRQ_MASK |=> reg_rdata[2:0] == $past(mask_sh))
		else $error("mask read back differs from last write");
endmodule // dtcru_chk
`default_nettype wire

// ===== sim/dtcru_pin_model.sv
// dtcru_pin_model: external pins and first-module inputs around the timer unit
// assumes flip_req is a one-cycle request driven right after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module dtcru_pin_model (
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	input  wire logic [6:0] flip_req,
	output logic      [6:0] pin
);
	// pins idle low, each request bit inverts its pin on the clock edge
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pin <= 7'h00;
		end else begin
			pin <= pin ^ flip_req;
		end
	end
endmodule // dtcru_pin_model
`default_nettype wire

// ===== sim/dtcru_test.sv
// dtcru_test: directed scenarios for the dual timer unit
// assumes dtcru_pkg, dtcru_top, dtcru_chk and dtcru_pin_model compiled first
`timescale 1ns/1ps
`default_nettype none
module dtcru_test;
	import dtcru_pkg::*;
	localparam int unsigned TW = 16;
	logic                ref_clk   = 1'b0;
	logic                sys_rst;
	logic [DTCRU_AW-1:0] reg_addr;
	logic [DTCRU_DW-1:0] reg_wdata;
	logic                reg_wr;
	logic                reg_rd;
	logic [6:0]          flip_req;
	wire logic [15:0]    reg_rdata;
	wire logic [6:0]     pin;
	wire logic           tog_pin;
	wire logic           cmp_clk;
	wire logic           irq;
	int                  n_fail      = 0;
	int                  checks_done = 0;
	int                  n_cmp       = 0;
	int                  k;
	logic [15:0]         v;
	logic [15:0]         cap_cfg [4] = '{16'h0001, 16'h0004, 16'h0008, 16'h000C};
	int                  cap_pin [4] = '{4, 5, 6, 5};

	always #4 ref_clk = ~ref_clk;
	// count compare pulses
	always @(posedge ref_clk) begin
		if (cmp_clk === 1'b1) n_cmp++;
	end

	dtcru_pin_model i_dtcru_pin_model (.ref_clk(ref_clk), .sys_rst(sys_rst), .flip_req(flip_req), .pin(pin));
	dtcru_top #(.TW(TW)) i_dtcru_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.aux_count_input(pin[0]), .core_count_input(pin[1]), .aux_direction_input_pin(pin[2]),
		.core_direction_input_pin(pin[3]), .capture_input_pin(pin[4]), .first_core_count_input(pin[5]),
		.first_core_direction_input(pin[6]), .toggle_output_pin(tog_pin), .compare_unit_clock(cmp_clk),
		.irq(irq));

	// ------------------------------
	// bus and compare helpers
	// ------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		@(posedge ref_clk);
	endtask
	task automatic rchk(input logic [3:0] a, input logic [15:0] e);
		rd(a, v);
		chk(v, e);
	endtask
	// one-cycle toggle request to the pin model, then edge detect and count settle
	task automatic flip(input int i);
		flip_req <= 7'h01 << i;
		@(posedge ref_clk);
		flip_req <= 7'h00;
		repeat (3) @(posedge ref_clk);
	endtask
	task automatic stop_test();
		if (n_fail == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ------------------------------
	// scenarios
	// ------------------------------
	task automatic t_prescale();
		for (int n = 0; n < 2; n++) begin
			wr(DTCRU_OFS_AUX_CNT, 16'h0000);
			wr(DTCRU_OFS_AUX_CFG, 16'h0001 | (16'(n) << DTCRU_TC_PRE_LO));
			repeat ((20 << n) - 2) @(posedge ref_clk);
			wr(DTCRU_OFS_AUX_CFG, 16'h0000);
			rd(DTCRU_OFS_AUX_CNT, v);
			chk({15'h0000, v >= 16'h0009 && v <= 16'h000B}, 16'h0001);
		end
	endtask
	task automatic t_wrap();
		wr(DTCRU_OFS_CORE_CNT, 16'h0000);
		wr(DTCRU_OFS_CORE_CFG, 16'h0B0B);  // pin clock, both edges, down, output on
		k = n_cmp;
		flip(1);
		rchk(DTCRU_OFS_CORE_CNT, 16'hFFFF);
		chk({15'h0000, tog_pin}, 16'h0001);
		chk(16'(n_cmp - k), 16'h0001);
		rd(DTCRU_OFS_CORE_CFG, v);
		chk({15'h0000, v[DTCRU_TC_LATCH]}, 16'h0001);
		rchk(DTCRU_OFS_IRQ_STAT, 16'h0002);
		chk({15'h0000, irq}, 16'h0000);
		wr(DTCRU_OFS_IRQ_MASK, 16'h0002);
		chk({15'h0000, irq}, 16'h0001);
		wr(DTCRU_OFS_IRQ_STAT, 16'h0002);
		chk({15'h0000, irq}, 16'h0000);
		rchk(DTCRU_OFS_IRQ_MASK, 16'h0002);
	endtask
	task automatic t_dir();
		wr(DTCRU_OFS_CORE_CNT, 16'h0005);
		wr(DTCRU_OFS_CORE_CFG, 16'h030D);  // pin clock, both edges, pin direction
		flip(3);
		flip(1);
		flip(1);
		rchk(DTCRU_OFS_CORE_CNT, 16'h0003);
		flip(3);
		flip(1);
		rchk(DTCRU_OFS_CORE_CNT, 16'h0004);
	endtask
	task automatic t_latch();
		wr(DTCRU_OFS_AUX_CNT, 16'h0000);
		wr(DTCRU_OFS_AUX_CFG, 16'h0011);  // aux clocked by toggle latch
		wr(DTCRU_OFS_CORE_CNT, 16'hFFFF);
		wr(DTCRU_OFS_CORE_CFG, 16'h0309);
		flip(1);
		rchk(DTCRU_OFS_AUX_CNT, 16'h0001);
		chk({15'h0000, tog_pin}, 16'h0000);
	endtask
	task automatic t_reload();
		wr(DTCRU_OFS_CAPTURE_RELOAD_REGISTER_VAL, 16'h1234);
		wr(DTCRU_OFS_CORE_CNT, 16'hFFFF);
		wr(DTCRU_OFS_CORE_CFG, 16'h0709);  // both edges, reload on wrap
		flip(1);
		rchk(DTCRU_OFS_CORE_CNT, 16'h1234);
		wr(DTCRU_OFS_CORE_CFG, 16'h0000);
	endtask
	task automatic t_capture();
		wr(DTCRU_OFS_AUX_CNT, 16'h0000);
		wr(DTCRU_OFS_AUX_CFG, 16'h0309);
		repeat (3) flip(0);
		wr(DTCRU_OFS_CAP_CFG, 16'h0012);  // falling edge, clear after capture
		flip(4);
		rchk(DTCRU_OFS_CAPTURE_RELOAD_REGISTER_VAL, 16'h1234);
		flip(4);
		rchk(DTCRU_OFS_CAPTURE_RELOAD_REGISTER_VAL, 16'h0003);
		rchk(DTCRU_OFS_AUX_CNT, 16'h0000);
		rd(DTCRU_OFS_IRQ_STAT, v);
		chk({15'h0000, v[DTCRU_IRQ_CAPTURE]}, 16'h0001);
		for (int i = 0; i < 4; i++) begin
			wr(DTCRU_OFS_CAP_CFG, cap_cfg[i]);
			flip(0);
			flip(cap_pin[i]);
			rchk(DTCRU_OFS_CAPTURE_RELOAD_REGISTER_VAL, 16'(i + 1));
		end
	endtask
	// aux direction from its pin, underflow sets the aux wrap flag
	task automatic t_auxdir();
		wr(DTCRU_OFS_AUX_CNT, 16'h0000);
		wr(DTCRU_OFS_AUX_CFG, 16'h030D);  // pin clock, both edges, pin direction
		flip(2);
		flip(0);
		rchk(DTCRU_OFS_AUX_CNT, 16'hFFFF);
		rd(DTCRU_OFS_IRQ_STAT, v);
		chk({15'h0000, v[DTCRU_IRQ_AUX_OVF]}, 16'h0001);
	endtask

	// main sequence
	initial begin
		sys_rst   <= 1'b1;
		reg_addr  <= 4'h0;
		reg_wdata <= 16'h0000;
		reg_wr    <= 1'b0;
		reg_rd    <= 1'b0;
		flip_req  <= 7'h00;
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		for (int i = 0; i < 9; i++) rchk(4'(i), 16'h0000);
		t_prescale();
		t_wrap();
		t_dir();
		t_latch();
		t_reload();
		t_capture();
		t_auxdir();
		stop_test();
	end
	// watchdog
	initial begin
		repeat (5000) @(posedge ref_clk);
		n_fail++;
		stop_test();
	end
endmodule // dtcru_test

bind dtcru_top dtcru_chk #(.TW(TW)) i_dtcru_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .toggle_output_pin(toggle_output_pin),
	.compare_unit_clock(compare_unit_clock), .irq(irq));
`default_nettype wire
